// ### rtl/dac_link_device.sv
`timescale 1ns/1ps
module dac_link_device
  import dac_link_pkg::*;
(
  // Register clock and reset
  input  wire logic   mclk,
  input  wire logic   arst_n,
  // Serial link
  dac_link_if.device  link,
  // Converter side
  output logic [19:0] dac_code,
  output logic        deglitch_bypass,
  output logic        clear_active,
  output logic        settling_mode_select,
  output logic [1:0]  deglitch_jump_threshold,
  output logic [1:0]  update_rate,
  output logic        deglitch_disable,
  output logic        fast_serial_out_enable
);

  logic [31:0] sr;
  logic [31:0] cap_word;
  logic [4:0]  cnt;
  logic        seen32;
  logic        fresh;
  logic        cap_tgl;
  logic [31:0] read_word;
  logic        read_armed;
  logic [23:0] cfg1;
  logic [23:0] cfg2;
  logic [7:0]  clrv;
  logic [19:0] code_buf;
  logic [19:0] next_code;
  logic        fs_m, fs_s, fs_d;
  logic        t_m, t_s, t_d;
  logic        ld_m, ld_s, ld_d;
  logic        cz_m, cz_s;

  // Link side, clocked by SCLK. A high frame select presets the start flag so
  // the count of the finished frame stays readable until the next frame.
  always_ff @(negedge link.sclk or negedge arst_n or posedge link.frame_sel_n) begin
    if (!arst_n) begin
      fresh <= 1'b1;
    end else if (link.frame_sel_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_ff @(negedge link.sclk or negedge arst_n) begin
    if (!arst_n) begin
      sr      <= 32'h00000000;
      cnt     <= 5'h00;
      seen32  <= 1'b0;
      cap_word <= 32'h00000000;
      cap_tgl <= 1'b0;
    end else if (!link.frame_sel_n) begin
      sr     <= {sr[30:0], link.sdi};
      cnt    <= fresh ? 5'h01 : cnt + 5'h01;
      seen32 <= fresh ? 1'b0 : (seen32 | (cnt == LAST_BIT));
      if (!fresh && !seen32 && cnt == LAST_BIT) begin
        cap_word <= {sr[30:0], link.sdi};
        cap_tgl  <= ~cap_tgl;
      end
    end
  end

  // Readback word and enables are only rewritten after the frame end has been
  // seen in the register domain, so they are static whenever SCLK runs.
  always_ff @(posedge link.sclk or negedge arst_n) begin
    if (!arst_n) begin
      link.sdo <= 1'b0;
    end else if (!cfg1[SDOEN_BIT]) begin
      link.sdo <= 1'b0;
    end else if (read_armed && (fresh || !seen32)) begin
      link.sdo <= read_word[LAST_BIT - (fresh ? 5'h00 : cnt)];
    end else begin
      link.sdo <= sr[31];
    end
  end

  // Synchronisers into the register domain.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {fs_m, fs_s, fs_d} <= 3'h7;
      {t_m, t_s, t_d}    <= 3'h0;
      {ld_m, ld_s, ld_d} <= 3'h7;
      {cz_m, cz_s}       <= 2'h3;
    end else begin
      {fs_m, fs_s, fs_d} <= {link.frame_sel_n, fs_m, fs_s};
      {t_m, t_s, t_d}    <= {cap_tgl, t_m, t_s};
      {ld_m, ld_s, ld_d} <= {link.load_output_n, ld_m, ld_s};
      {cz_m, cz_s}       <= {link.async_zero_input_n, cz_m};
    end
  end

  logic        frame_end;
  logic        frame_ok;
  logic        wr_ok;
  logic        rd_ok;
  logic [6:0]  addr;
  logic [23:0] d;
  logic        soft_rst;
  logic        sw_clr;
  logic        clr_low;
  logic        upd_fe;
  logic        upd_32;
  logic        upd_ld;
  logic [23:0] wmask;
  logic [23:0] rd_data;

  assign frame_end = fs_s & ~fs_d;
  assign frame_ok  = seen32 && (cnt == 5'h00);
  assign addr      = sr[ADDR_MSB:ADDR_LSB];
  assign d         = sr[23:0];
  assign wr_ok     = frame_end & frame_ok & ~sr[RW_BIT];
  assign rd_ok     = frame_end & frame_ok & sr[RW_BIT];
  assign soft_rst  = wr_ok & (addr == ADDR_TRIG) & d[SWRST_BIT];
  assign sw_clr    = wr_ok & (addr == ADDR_TRIG) & d[SWCLR_BIT] & ~soft_rst;
  assign clr_low   = ~cz_s;
  assign upd_fe    = wr_ok & (addr == ADDR_CODE) & ~cfg1[UPDMODE_BIT] & ~cfg1[SDOEN_BIT];
  assign upd_32    = (t_s ^ t_d) & ~cfg1[UPDMODE_BIT] & cfg1[SDOEN_BIT] & ~cap_word[RW_BIT]
                     & (cap_word[ADDR_MSB:ADDR_LSB] == ADDR_CODE);
  assign upd_ld    = ld_d & ~ld_s & cfg1[UPDMODE_BIT];
  // Threshold bits keep their value unless fast settling and deglitch are on.
  assign wmask     = (~cfg1[SETTLE_BIT] & ~cfg2[DGDIS_BIT]) ? CFG1_WMASK
                     : (CFG1_WMASK & ~CFG1_TMASK);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg1 <= CFG1_RESET;
    end else if (soft_rst) begin
      cfg1 <= CFG1_RESET;
    end else if (wr_ok && addr == ADDR_CFG1) begin
      cfg1 <= (d & wmask) | (cfg1 & ~wmask);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg2 <= CFG2_RESET;
    end else if (soft_rst) begin
      cfg2 <= CFG2_RESET;
    end else if (wr_ok && addr == ADDR_CFG2) begin
      cfg2 <= (d & CFG2_WMASK) | (cfg2 & ~CFG2_WMASK);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clrv <= CLRV_RESET;
    end else if (soft_rst) begin
      clrv <= CLRV_RESET;
    end else if (wr_ok && addr == ADDR_CLRV) begin
      clrv <= d[CLRV_MSB:CLRV_LSB];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      code_buf <= CODE_RESET;
    end else if (soft_rst) begin
      code_buf <= CODE_RESET;
    end else if (clr_low || sw_clr) begin
      code_buf <= {clrv, CLRV_PAD};
    end else if (wr_ok && addr == ADDR_CODE) begin
      code_buf <= d[CODE_MSB:CODE_LSB];
    end
  end

  always_comb begin
    next_code = dac_code;
    if (soft_rst) begin
      next_code = CODE_RESET;
    end else if (clr_low || sw_clr) begin
      next_code = {clrv, CLRV_PAD};
    end else if (upd_32) begin
      next_code = cap_word[CODE_MSB:CODE_LSB];
    end else if (upd_fe) begin
      next_code = d[CODE_MSB:CODE_LSB];
    end else if (upd_ld) begin
      next_code = code_buf;
    end
  end

  // Bypass pulses for one cycle when the output steps past the threshold.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code        <= CODE_RESET;
      deglitch_bypass <= 1'b0;
    end else begin
      dac_code        <= next_code;
      deglitch_bypass <= ~cfg2[DGDIS_BIT] &
        (((next_code > dac_code) ? (next_code - dac_code) : (dac_code - next_code))
         > jump_limit(cfg1[MASK_MSB:MASK_LSB]));
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clear_active <= 1'b0;
    end else if (soft_rst) begin
      clear_active <= 1'b0;
    end else if (clr_low || sw_clr) begin
      clear_active <= 1'b1;
    end else if (wr_ok) begin
      clear_active <= 1'b0;
    end
  end

  always_comb begin
    unique case (addr)
      ADDR_CODE: rd_data = {code_buf, 4'h0};
      ADDR_CFG1: rd_data = cfg1;
      ADDR_CLRV: rd_data = {clrv, 16'h0000};
      ADDR_CFG2: rd_data = cfg2;
      default:   rd_data = 24'h000000;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      read_armed <= 1'b0;
      read_word  <= 32'h00000000;
    end else if (frame_end) begin
      read_armed <= rd_ok & ~soft_rst;
      if (rd_ok) begin
        read_word <= {1'b1, addr, rd_data};
      end
    end
  end

  assign settling_mode_select    = cfg1[SETTLE_BIT];
  assign deglitch_jump_threshold = cfg1[MASK_MSB:MASK_LSB];
  assign fast_serial_out_enable  = cfg1[FASTSDO_BIT];
  assign update_rate             = cfg2[RATE_MSB:RATE_LSB];
  assign deglitch_disable        = cfg2[DGDIS_BIT];

endmodule

// ### include/dac_link_pkg.sv
package dac_link_pkg;

  // Frame layout.
  localparam int          FRAME_BITS = 32;
  localparam logic [4:0]  LAST_BIT   = 5'h1F;
  localparam int          RW_BIT     = 31;
  localparam int          ADDR_MSB   = 30;
  localparam int          ADDR_LSB   = 24;

  // Register offsets.
  localparam logic [6:0]  ADDR_NOP   = 7'h00;
  localparam logic [6:0]  ADDR_CODE  = 7'h01;
  localparam logic [6:0]  ADDR_CFG1  = 7'h02;
  localparam logic [6:0]  ADDR_CLRV  = 7'h03;
  localparam logic [6:0]  ADDR_TRIG  = 7'h04;
  localparam logic [6:0]  ADDR_STAT  = 7'h05;
  localparam logic [6:0]  ADDR_CFG2  = 7'h06;

  // Field positions inside the 24-bit data field.
  localparam int          CODE_MSB    = 23;
  localparam int          CODE_LSB    = 4;
  localparam int          CLRV_MSB    = 23;
  localparam int          CLRV_LSB    = 16;
  localparam int          MASK_MSB    = 19;
  localparam int          MASK_LSB    = 18;
  localparam int          UPDMODE_BIT = 14;
  localparam int          FASTSDO_BIT = 13;
  localparam int          SDOEN_BIT   = 11;
  localparam int          SETTLE_BIT  = 10;
  localparam int          SWRST_BIT   = 6;
  localparam int          SWCLR_BIT   = 5;
  localparam int          DGDIS_BIT   = 7;
  localparam int          RATE_MSB    = 5;
  localparam int          RATE_LSB    = 4;

  // Reset values and writable masks.
  localparam logic [23:0] CFG1_RESET = 24'h004C80;
  localparam logic [23:0] CFG1_WMASK = 24'h8C7FD0;
  localparam logic [23:0] CFG1_TMASK = 24'h0C0000;
  localparam logic [23:0] CFG2_RESET = 24'h000040;
  localparam logic [23:0] CFG2_WMASK = 24'h0000B0;
  localparam logic [19:0] CODE_RESET = 20'h00000;
  localparam logic [7:0]  CLRV_RESET = 8'h00;
  localparam logic [11:0] CLRV_PAD   = 12'h000;

  // Deglitch bypass thresholds.
  localparam logic [19:0] JUMP_LIMIT_0 = 20'h04000;
  localparam logic [19:0] JUMP_LIMIT_1 = 20'h08000;
  localparam logic [19:0] JUMP_LIMIT_2 = 20'h02000;
  localparam logic [19:0] JUMP_LIMIT_3 = 20'h01000;

  // Host timing on the 20 MHz clock.
  localparam int          MCLK_PERIOD_NS = 50;
  localparam int          LOAD_PULSE_NS  = 100;
  localparam logic [3:0]  LOAD_PULSE_CYC = 4'(LOAD_PULSE_NS / MCLK_PERIOD_NS);
  localparam int          FRAME_GAP_NS   = 400;
  localparam logic [3:0]  FRAME_GAP_CYC  = 4'(FRAME_GAP_NS / MCLK_PERIOD_NS);
  localparam logic [1:0]  PHASE_RISE     = 2'h0;
  localparam logic [1:0]  PHASE_FALL     = 2'h2;
  localparam logic [1:0]  PHASE_SAMPLE   = 2'h3;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_LEAD  = 3'b001,
    H_SHIFT = 3'b010,
    H_TAIL  = 3'b011,
    H_GAP   = 3'b100
  } host_state_t;

  function automatic logic [19:0] jump_limit(input logic [1:0] sel);
    logic [19:0] lim;
    unique case (sel)
      2'b00: lim = JUMP_LIMIT_0;
      2'b01: lim = JUMP_LIMIT_1;
      2'b10: lim = JUMP_LIMIT_2;
      2'b11: lim = JUMP_LIMIT_3;
    endcase
    return lim;
  endfunction

endpackage

// ### include/dac_link_if.sv
`timescale 1ns/1ps
interface dac_link_if;
  logic frame_sel_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic async_zero_input_n;
  logic load_output_n;

  modport device (
    input  frame_sel_n,
    input  sclk,
    input  sdi,
    input  async_zero_input_n,
    input  load_output_n,
    output sdo
  );

  modport host (
    output frame_sel_n,
    output sclk,
    output sdi,
    output async_zero_input_n,
    output load_output_n,
    input  sdo
  );
endinterface

// ### rtl/dac_link_host.sv
`timescale 1ns/1ps
module dac_link_host
  import dac_link_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Serial link
  dac_link_if.host         link,
  // Frame requests
  input  wire logic        req_valid,
  input  wire logic        req_read,
  input  wire logic [6:0]  req_addr,
  input  wire logic [23:0] req_data,
  output logic             req_ready,
  // Frame results
  output logic             resp_valid,
  output logic [31:0]      resp_data,
  // Side pins
  input  wire logic        load_req,
  input  wire logic        hold_load_low,
  input  wire logic        clear_req
);

  host_state_t state;
  logic [31:0] tx;
  logic [31:0] rx;
  logic [1:0]  phase;
  logic [4:0]  bitn;
  logic [3:0]  gap;
  logic [3:0]  load_cnt;
  logic        sdo_m, sdo_s;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {sdo_m, sdo_s} <= 2'h0;
    end else begin
      {sdo_m, sdo_s} <= {link.sdo, sdo_m};
    end
  end

  // SCLK is mclk divided by four; data moves on the rise, the device samples
  // on the fall, and SDO is read a quarter period after the fall.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state            <= H_IDLE;
      req_ready        <= 1'b1;
      resp_valid       <= 1'b0;
      resp_data        <= 32'h00000000;
      link.frame_sel_n <= 1'b1;
      link.sclk        <= 1'b0;
      link.sdi         <= 1'b0;
      tx               <= 32'h00000000;
      rx               <= 32'h00000000;
      phase            <= 2'h0;
      bitn             <= 5'h00;
      gap              <= 4'h0;
    end else begin
      resp_valid <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (req_valid) begin
            tx               <= {req_read, req_addr, req_data};
            link.frame_sel_n <= 1'b0;
            req_ready        <= 1'b0;
            state            <= H_LEAD;
          end
        end
        H_LEAD: begin
          phase <= PHASE_RISE;
          bitn  <= 5'h00;
          state <= H_SHIFT;
        end
        H_SHIFT: begin
          phase <= phase + 2'h1;
          if (phase == PHASE_RISE) begin
            link.sclk <= 1'b1;
            link.sdi  <= tx[31];
            tx        <= {tx[30:0], 1'b0};
          end else if (phase == PHASE_FALL) begin
            link.sclk <= 1'b0;
          end else if (phase == PHASE_SAMPLE) begin
            rx <= {rx[30:0], sdo_s};
            if (bitn == LAST_BIT) begin
              state <= H_TAIL;
            end else begin
              bitn <= bitn + 5'h01;
            end
          end
        end
        H_TAIL: begin
          link.frame_sel_n <= 1'b1;
          resp_valid       <= 1'b1;
          resp_data        <= rx;
          gap              <= FRAME_GAP_CYC;
          state            <= H_GAP;
        end
        H_GAP: begin
          if (gap == 4'h0) begin
            req_ready <= 1'b1;
            state     <= H_IDLE;
          end else begin
            gap <= gap - 4'h1;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // Load pulse in synchronous mode, or held low for asynchronous updates.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      load_cnt           <= 4'h0;
      link.load_output_n <= 1'b1;
    end else begin
      if (load_req && load_cnt == 4'h0) begin
        load_cnt <= LOAD_PULSE_CYC;
      end else if (load_cnt != 4'h0) begin
        load_cnt <= load_cnt - 4'h1;
      end
      link.load_output_n <= ~(hold_load_low | (load_req & load_cnt == 4'h0)
                              | (load_cnt > 4'h1));
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.async_zero_input_n <= 1'b1;
    end else begin
      link.async_zero_input_n <= ~clear_req;
    end
  end

endmodule

// ### sim/dac_link_properties.sv
`timescale 1ns/1ps
module dac_link_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link wires
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic async_zero_input_n,
  input wire logic load_output_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Counting on mclk works because the link clock is a quarter of it.
  logic       sclk_q;
  logic [6:0] rise_cnt;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q   <= 1'h0;
      rise_cnt <= 7'h00;
    end else begin
      sclk_q <= sclk;
      if (frame_sel_n)
        rise_cnt <= 7'h00;
      else if (sclk && !sclk_q)
        rise_cnt <= rise_cnt + 7'h01;
    end
  end

  property p_frame_bits; $rose(frame_sel_n) |-> rise_cnt == 7'h20; endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("Frame length wrong.");
  property p_sclk_idle; frame_sel_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("Clock outside frame.");
  property p_gap; $rose(frame_sel_n) |-> frame_sel_n [*4]; endproperty
  a_gap: assert property (p_gap) else $error("Frame gap too short.");
  property p_shape; $rose(sclk) |-> ##1 sclk ##1 !sclk; endproperty
  a_shape: assert property (p_shape) else $error("Clock high time wrong.");
  property p_sdi_hold; $fell(sclk) |-> $stable(sdi); endproperty
  a_sdi_hold: assert property (p_sdi_hold) else $error("Input moved at sample.");
  property p_sdo_launch;
    !frame_sel_n && !$past(frame_sel_n) && $changed(sdo) |-> $rose(sclk);
  endproperty
  a_sdo_launch: assert property (p_sdo_launch) else $error("Output moved off rise.");
  property p_sdo_hold; $fell(sclk) |-> $stable(sdo); endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("Output moved at fall.");
  property p_load; $fell(load_output_n) |-> !load_output_n [*2]; endproperty
  a_load: assert property (p_load) else $error("Load pulse too short.");

  c_frame: cover property ($rose(frame_sel_n));
  c_load: cover property ($fell(load_output_n));
  c_clear: cover property ($fell(async_zero_input_n));
endmodule

// ### sim/dac_serial_register_interface_tb_top.sv
`timescale 1ns/1ps
module dac_serial_register_interface_tb_top
  import dac_link_pkg::*;
();
  logic        mclk, arst_n, req_valid, req_read, req_ready, resp_valid;
  logic        load_req, hold_load_low, clear_req, clear_active, deglitch_bypass;
  logic        settling_mode_select, deglitch_disable, fast_serial_out_enable;
  logic [1:0]  deglitch_jump_threshold, update_rate;
  logic [6:0]  req_addr;
  logic [19:0] dac_code, code_early;
  logic [23:0] req_data;
  logic [31:0] resp_data, rx;
  int          err_total, comparisons, nbyp;

  dac_link_if link ();

  dac_link_host i_dac_link_host (
    .mclk(mclk), .arst_n(arst_n), .link(link.host), .req_valid(req_valid),
    .req_read(req_read), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .load_req(load_req),
    .hold_load_low(hold_load_low), .clear_req(clear_req)
  );
  dac_link_device i_dac_link_device (
    .mclk(mclk), .arst_n(arst_n), .link(link.device), .dac_code(dac_code),
    .deglitch_bypass(deglitch_bypass), .clear_active(clear_active),
    .settling_mode_select(settling_mode_select),
    .deglitch_jump_threshold(deglitch_jump_threshold), .update_rate(update_rate),
    .deglitch_disable(deglitch_disable), .fast_serial_out_enable(fast_serial_out_enable)
  );
  dac_link_properties i_dac_link_properties (
    .mclk(mclk), .arst_n(arst_n), .frame_sel_n(link.frame_sel_n), .sclk(link.sclk),
    .sdi(link.sdi), .sdo(link.sdo), .async_zero_input_n(link.async_zero_input_n),
    .load_output_n(link.load_output_n)
  );

  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  // Counted mid-cycle so the one-cycle pulse is read where it has settled.
  always @(negedge mclk) begin
    if (deglitch_bypass === 1'h1)
      nbyp++;
  end

  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic xfer(input logic rd, input logic [6:0] a, input logic [23:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'h1 && n++ < 300) tick(1);
    req_read  = rd;
    req_addr  = a;
    req_data  = d;
    req_valid = 1'h1;
    tick(1);
    req_valid = 1'h0;
    n = 0;
    while (resp_valid !== 1'h1 && n++ < 300) tick(1);
    if (n > 300)
      err_total++;
    rx = resp_data;
    tick(1);
    code_early = dac_code;
    tick(5);
  endtask

  // A read word only comes back in the frame after the read.
  task automatic rdreg(input logic [6:0] a);
    xfer(1'h1, a, 24'h000000);
    xfer(1'h0, ADDR_NOP, 24'h000000);
  endtask

  task automatic ld();
    load_req = 1'h1;
    tick(1);
    load_req = 1'h0;
    tick(10);
  endtask

  task automatic t_reset_state();
    chk(32'(dac_code), 32'h0);
    chk(32'(settling_mode_select), 32'h1);
    rdreg(ADDR_CFG1);
    chk(rx, {1'h1, ADDR_CFG1, 24'h004C80});
  endtask

  task automatic t_sync_update();
    xfer(1'h0, ADDR_CODE, 24'h123450);
    chk(32'(dac_code), 32'h0);
    xfer(1'h0, ADDR_NOP, 24'h000000);
    chk(rx, {1'h0, ADDR_CODE, 24'h123450});
    ld();
    chk(32'(dac_code), 32'h12345);
    chk(32'(nbyp), 32'h1);
    ld();
    chk(32'(dac_code), 32'h12345);
  endtask

  task automatic t_threshold();
    xfer(1'h0, ADDR_CFG1, 24'h0C4C80);
    chk(32'(deglitch_jump_threshold), 32'h0);
    xfer(1'h0, ADDR_CFG1, 24'h004880);
    chk(32'(settling_mode_select), 32'h0);
    xfer(1'h0, ADDR_CFG1, 24'h0C6880);
    chk(32'(deglitch_jump_threshold), 32'h3);
    chk(32'(fast_serial_out_enable), 32'h1);
    xfer(1'h0, ADDR_CODE, 24'h134560);
    ld();
    chk(32'(nbyp), 32'h2);
  endtask

  task automatic t_cfg2_unmapped();
    logic [6:0] bad [3];
    bad = '{ADDR_STAT, 7'h07, 7'h7F};
    xfer(1'h0, ADDR_CFG2, 24'hFFFFFF);
    chk(32'(update_rate), 32'h3);
    chk(32'(deglitch_disable), 32'h1);
    xfer(1'h0, ADDR_CFG1, 24'h006880);
    chk(32'(deglitch_jump_threshold), 32'h3);
    rdreg(ADDR_CFG2);
    chk(rx, {1'h1, ADDR_CFG2, 24'h0000F0});
    foreach (bad[i]) xfer(1'h0, bad[i], 24'hFFFFFF);
    ld();
    chk(32'(dac_code), 32'h13456);
    rdreg(ADDR_CFG1);
    chk(rx, {1'h1, ADDR_CFG1, 24'h0C6880});
  endtask

  task automatic t_async_clear();
    hold_load_low = 1'h1;
    xfer(1'h0, ADDR_CFG1, 24'h0C2080);
    xfer(1'h0, ADDR_CODE, 24'h200000);
    chk(32'(dac_code), 32'h20000);
    chk(32'(code_early), 32'h13456);
    chk(32'(nbyp), 32'h2);
    rdreg(ADDR_CODE);
    chk(rx, 32'h0);
    xfer(1'h0, ADDR_CLRV, 24'hA50000);
    clear_req = 1'h1;
    tick(8);
    chk(32'(dac_code), 32'hA5000);
    chk(32'(clear_active), 32'h1);
    clear_req = 1'h0;
    xfer(1'h0, ADDR_CODE, 24'h111110);
    chk(32'(clear_active), 32'h0);
    chk(32'(dac_code), 32'h11111);
  endtask

  task automatic t_soft();
    xfer(1'h0, ADDR_TRIG, 24'h000020);
    chk(32'(dac_code), 32'hA5000);
    xfer(1'h0, ADDR_TRIG, 24'h000040);
    chk(32'(dac_code), 32'h0);
    chk(32'(update_rate), 32'h0);
    chk(32'(fast_serial_out_enable), 32'h0);
    hold_load_low = 1'h0;
    rdreg(ADDR_CFG1);
    chk(rx, {1'h1, ADDR_CFG1, 24'h004C80});
  endtask

  // With output enabled the code must already move before the frame end is seen.
  task automatic t_async_early();
    hold_load_low = 1'h1;
    xfer(1'h0, ADDR_CFG1, 24'h000C80);
    xfer(1'h0, ADDR_CODE, 24'hABCDE0);
    chk(32'(code_early), 32'hABCDE);
    chk(32'(dac_code), 32'hABCDE);
    chk(32'(nbyp), 32'h3);
  endtask

  initial begin
    arst_n = 1'h0;
    req_valid = 1'h0;
    req_read = 1'h0;
    req_addr = 7'h00;
    req_data = 24'h000000;
    load_req = 1'h0;
    hold_load_low = 1'h0;
    clear_req = 1'h0;
    err_total = 0;
    comparisons = 0;
    nbyp = 0;
    tick(8);
    arst_n = 1'h1;
    tick(4);
    t_reset_state();
    t_sync_update();
    t_threshold();
    t_cfg2_unmapped();
    t_async_clear();
    t_soft();
    t_async_early();
    report_and_stop();
  end

  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
endmodule
